// ### design/tmch_map.vh
// Purpose: register map, field positions and reset values of the timer channel block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   definitions only
`ifndef TMCH_MAP_VH
`define TMCH_MAP_VH

`define TMCH_ADDR_CSC       8'h00
`define TMCH_ADDR_CTRL      8'h04
`define TMCH_ADDR_MOD       8'h08
`define TMCH_ADDR_CHV       8'h0C
`define TMCH_ADDR_CNT       8'h10
`define TMCH_ADDR_ISTS      8'h14
`define TMCH_ADDR_IMASK     8'h18

`define TMCH_CSC_FLAG       7
`define TMCH_CSC_IE         6
`define TMCH_CSC_MODE_B     5
`define TMCH_CSC_MODE_A     4
`define TMCH_CSC_ELS_B      3
`define TMCH_CSC_ELS_A      2
`define TMCH_CSC_RST        8'h00

`define TMCH_CTRL_EN        0
`define TMCH_CTRL_CAS       5

`define TMCH_IRQ_CH         0
`define TMCH_IRQ_OVF        1
`define TMCH_IRQ_W          2

`define TMCH_MOD_RST        16'h0000
`define TMCH_CHV_RST        16'h0000

`define TMCH_RESP_OKAY      2'b00
`define TMCH_RESP_SLVERR    2'b10

`endif

// ### design/tmch_sync.v
// Purpose: two-stage synchroniser for the channel pin
// Assumes: i_async comes from outside the bus clock domain
// Notes:   only the second stage leaves the module
`timescale 1ns/1ps
module tmch_sync (
    input  wire i_clk,
    input  wire i_rstn,
    input  wire i_async,
    output wire o_sync
);
    reg meta_q;
    reg sync_q;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// ### design/tmch_counter.v
// Purpose: main timer counter, up or up/down, with modulo
// Assumes: one count per clock while enabled
// Notes:   modulo 0 runs free to all ones
`timescale 1ns/1ps
module tmch_counter #(
    parameter W = 16
) (
    input  wire         i_clk,
    input  wire         i_rstn,
    input  wire         i_en,
    input  wire         i_clr,
    input  wire         i_updown,
    input  wire [W-1:0] i_modulo,
    output wire [W-1:0] o_count,
    output wire         o_down,
    output wire         o_ovf
);
    reg  [W-1:0] cnt_q;
    reg          down_q;
    reg          ovf_q;
    wire [W-1:0] top;

    assign top = (i_modulo == {W{1'b0}}) ? {W{1'b1}} : i_modulo;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q  <= {W{1'b0}};
            down_q <= 1'b0;
            ovf_q  <= 1'b0;
        end else begin
            ovf_q <= 1'b0;
            if (i_clr) begin
                cnt_q  <= {W{1'b0}};
                down_q <= 1'b0;
            end else if (i_en) begin
                if (!i_updown) begin
                    down_q <= 1'b0;
                    if (cnt_q >= top) begin
                        cnt_q <= {W{1'b0}};
                        ovf_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end else if (!down_q) begin
                    // turn at top, overflow marks end of period
                    if (cnt_q >= top) begin
                        down_q <= 1'b1;
                        cnt_q  <= cnt_q - 1'b1;
                        ovf_q  <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end else begin
                    if (cnt_q == {W{1'b0}}) begin
                        down_q <= 1'b0;
                        cnt_q  <= cnt_q + 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
            end
        end
    end

    assign o_count = cnt_q;
    assign o_down  = down_q;
    assign o_ovf   = ovf_q;
endmodule

// ### design/tmch_top.v
// Purpose: timer channel status/control, mode decode, pin action, AXI4-Lite registers
// Assumes: single bus clock, pin input asynchronous
// Notes:   channel value and counter are 16 bits in the low half of their words
// Functional notes
// - input capture sets the channel flag on the selected pin edge
// - output compare and edge PWM set the flag on counter match
// - center-aligned PWM sets the flag on every match, up and down
// - channel interrupt request while flag set and enable is one
// - flag clears only after a read with flag set, then writing zero
// - an event between arming read and clearing write keeps the flag set
// - writing one to the flag does nothing; reset clears it
// - interrupt enable is read/write, zero after reset
// - center select zero and mode B one gives edge-aligned PWM
// - mode bits 00 is input capture, 01 is output compare
// - edge/level select 00 releases the pin in every mode
// - capture on rising 01, falling 10, either edge 11
// - compare: 00 no pin, 01 toggle, 10 clear, 11 set
// - edge PWM: 10 high-true cleared on match, X1 low-true set on match
// - center PWM: 10 high-true cleared up-match, X1 low-true set up-match
// - center select makes counter up/down and every channel center PWM
// - an active capture edge copies the counter into the channel value
`timescale 1ns/1ps
`include "tmch_map.vh"
module tmch_top #(
    parameter AW = 8,
    parameter CW = 16
) (
    input  wire          I_CLK,
    input  wire          I_RSTN,
    input  wire [AW-1:0] I_AWADDR,
    input  wire          I_AWVALID,
    output wire          O_AWREADY,
    input  wire [31:0]   I_WDATA,
    input  wire [3:0]    I_WSTRB,
    input  wire          I_WVALID,
    output wire          O_WREADY,
    output wire [1:0]    O_BRESP,
    output wire          O_BVALID,
    input  wire          I_BREADY,
    input  wire [AW-1:0] I_ARADDR,
    input  wire          I_ARVALID,
    output wire          O_ARREADY,
    output wire [31:0]   O_RDATA,
    output wire [1:0]    O_RRESP,
    output wire          O_RVALID,
    input  wire          I_RREADY,
    input  wire          I_CH_PIN,
    output wire          O_CH_PIN,
    output wire          O_CH_PIN_OE_N,
    output wire          O_PIN_RELEASED,
    output wire          O_CH_IRQ,
    output wire          O_IRQ
);
    // byte-lane merge of a write into a stored word
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    // register state
    reg  [7:0]              csc_q;
    reg                     armed_q;
    reg                     cas_q;
    reg                     en_q;
    reg  [CW-1:0]           mod_q;
    reg  [CW-1:0]           chv_q;
    reg  [`TMCH_IRQ_W-1:0]  ists_q;
    reg  [`TMCH_IRQ_W-1:0]  imask_q;
    reg                     pin_q;
    reg                     pin_prev_q;

    // bus state
    reg                     aw_hold_q;
    reg  [AW-1:0]           awaddr_q;
    reg                     w_hold_q;
    reg  [31:0]             wdata_q;
    reg  [3:0]              wstrb_q;
    reg                     bvalid_q;
    reg  [1:0]              bresp_q;
    reg                     rvalid_q;
    reg  [1:0]              rresp_q;
    reg  [31:0]             rdata_q;

    wire                    aw_take;
    wire                    w_take;
    wire                    aw_have;
    wire                    w_have;
    wire                    wr_fire;
    wire [AW-1:0]           wr_addr;
    wire [31:0]             wr_data;
    wire [3:0]              wr_strb;
    wire                    rd_fire;
    reg  [31:0]             rd_mux;
    reg                     rd_ok;
    reg                     wr_ok;

    wire                    csc_wr;
    wire                    csc_rd;
    wire [31:0]             csc_new;
    wire [31:0]             ctrl_new;
    wire [31:0]             mod_new;
    wire [31:0]             chv_new;
    wire [31:0]             ists_wr;
    wire [31:0]             imask_new;

    wire [CW-1:0]           cnt;
    wire                    cnt_down;
    wire                    ovf;
    wire                    pin_s;

    wire                    flag;
    wire [1:0]              els;
    wire                    pin_used;
    wire                    mode_ic;
    wire                    mode_oc;
    wire                    mode_epwm;
    wire                    mode_cpwm;
    wire                    match;
    wire                    period_start;
    wire                    rise;
    wire                    fall;
    wire                    cap_evt;
    wire                    ch_evt;
    reg                     pin_d;

    // write channel: address and data taken in either order
    assign O_AWREADY = !aw_hold_q && !bvalid_q;
    assign O_WREADY  = !w_hold_q && !bvalid_q;
    assign aw_take   = I_AWVALID && O_AWREADY;
    assign w_take    = I_WVALID && O_WREADY;
    assign aw_have   = aw_hold_q || aw_take;
    assign w_have    = w_hold_q || w_take;
    assign wr_fire   = aw_have && w_have && !bvalid_q;
    assign wr_addr   = aw_hold_q ? awaddr_q : I_AWADDR;
    assign wr_data   = w_hold_q ? wdata_q : I_WDATA;
    assign wr_strb   = w_hold_q ? wstrb_q : I_WSTRB;

    assign O_ARREADY = !rvalid_q;
    assign rd_fire   = I_ARVALID && O_ARREADY;

    assign csc_wr    = wr_fire && (wr_addr == `TMCH_ADDR_CSC);
    assign csc_rd    = rd_fire && (I_ARADDR == `TMCH_ADDR_CSC);
    assign csc_new   = merge({24'h0000_00, csc_q}, wr_data, wr_strb);
    assign ctrl_new  = merge({26'h000_0000, cas_q, 4'h0, en_q}, wr_data, wr_strb);
    assign mod_new   = merge({16'h0000, mod_q}, wr_data, wr_strb);
    assign chv_new   = merge({16'h0000, chv_q}, wr_data, wr_strb);
    assign ists_wr   = merge(32'h0000_0000, wr_data, wr_strb);
    assign imask_new = merge({30'h0000_0000, imask_q}, wr_data, wr_strb);

    always @* begin
        wr_ok = 1'b1;
        case (wr_addr)
            `TMCH_ADDR_CSC,
            `TMCH_ADDR_CTRL,
            `TMCH_ADDR_MOD,
            `TMCH_ADDR_CHV,
            `TMCH_ADDR_CNT,
            `TMCH_ADDR_ISTS,
            `TMCH_ADDR_IMASK: wr_ok = 1'b1;
            default:          wr_ok = 1'b0;
        endcase
    end

    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (I_ARADDR)
            `TMCH_ADDR_CSC:   rd_mux = {24'h0000_00, csc_q};
            `TMCH_ADDR_CTRL:  rd_mux = {26'h000_0000, cas_q, 4'h0, en_q};
            `TMCH_ADDR_MOD:   rd_mux = {16'h0000, mod_q};
            `TMCH_ADDR_CHV:   rd_mux = {16'h0000, chv_q};
            `TMCH_ADDR_CNT:   rd_mux = {16'h0000, cnt};
            `TMCH_ADDR_ISTS:  rd_mux = {30'h0000_0000, ists_q};
            `TMCH_ADDR_IMASK: rd_mux = {30'h0000_0000, imask_q};
            default:          rd_ok  = 1'b0;
        endcase
    end

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= {AW{1'b0}};
            w_hold_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `TMCH_RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= `TMCH_RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else begin
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? `TMCH_RESP_OKAY : `TMCH_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q  <= I_AWADDR;
                end
                if (w_take) begin
                    w_hold_q <= 1'b1;
                    wdata_q  <= I_WDATA;
                    wstrb_q  <= I_WSTRB;
                end
                if (bvalid_q && I_BREADY) begin
                    bvalid_q <= 1'b0;
                end
            end
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= rd_ok ? `TMCH_RESP_OKAY : `TMCH_RESP_SLVERR;
            end else if (rvalid_q && I_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign O_BVALID = bvalid_q;
    assign O_BRESP  = bresp_q;
    assign O_RVALID = rvalid_q;
    assign O_RDATA  = rdata_q;
    assign O_RRESP  = rresp_q;

    // counter runs up/down whenever center select is set
    tmch_counter #(
        .W        (CW)
    ) u_counter (
        .i_clk    (I_CLK),
        .i_rstn   (I_RSTN),
        .i_en     (en_q),
        .i_clr    (wr_fire && (wr_addr == `TMCH_ADDR_CNT)),
        .i_updown (cas_q),
        .i_modulo (mod_q),
        .o_count  (cnt),
        .o_down   (cnt_down),
        .o_ovf    (ovf)
    );

    tmch_sync u_pin_sync (
        .i_clk    (I_CLK),
        .i_rstn   (I_RSTN),
        .i_async  (I_CH_PIN),
        .o_sync   (pin_s)
    );

    // mode decode
    assign flag      = csc_q[`TMCH_CSC_FLAG];
    assign els       = {csc_q[`TMCH_CSC_ELS_B], csc_q[`TMCH_CSC_ELS_A]};
    assign pin_used  = (els != 2'b00);
    assign mode_cpwm = cas_q;
    assign mode_epwm = !cas_q && csc_q[`TMCH_CSC_MODE_B];
    assign mode_ic   = !cas_q && !csc_q[`TMCH_CSC_MODE_B] && !csc_q[`TMCH_CSC_MODE_A];
    assign mode_oc   = !cas_q && !csc_q[`TMCH_CSC_MODE_B] && csc_q[`TMCH_CSC_MODE_A];

    assign match        = en_q && (cnt == chv_q);
    assign period_start = en_q && (cnt == {CW{1'b0}}) && !cnt_down;

    // edges seen only on the synchronised pin
    assign rise    = pin_s && !pin_prev_q;
    assign fall    = !pin_s && pin_prev_q;
    assign cap_evt = mode_ic && ((els[0] && rise) || (els[1] && fall));
    assign ch_evt  = cap_evt || (!mode_ic && match);

    // pin level for the next cycle
    always @* begin
        pin_d = pin_q;
        if (!pin_used) begin
            pin_d = pin_q;
        end else if (mode_oc && match) begin
            case (els)
                2'b01:   pin_d = !pin_q;
                2'b10:   pin_d = 1'b0;
                2'b11:   pin_d = 1'b1;
                default: pin_d = pin_q;
            endcase
        end else if (mode_epwm) begin
            if (match) begin
                pin_d = els[0];
            end else if (period_start) begin
                pin_d = !els[0];
            end
        end else if (mode_cpwm && match) begin
            pin_d = cnt_down ? !els[0] : els[0];
        end
    end

    always @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            csc_q      <= `TMCH_CSC_RST;
            armed_q    <= 1'b0;
            cas_q      <= 1'b0;
            en_q       <= 1'b0;
            mod_q      <= `TMCH_MOD_RST;
            chv_q      <= `TMCH_CHV_RST;
            ists_q     <= {`TMCH_IRQ_W{1'b0}};
            imask_q    <= {`TMCH_IRQ_W{1'b0}};
            pin_q      <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_s;
            pin_q      <= pin_d;

            // control bits; flag is never written directly
            if (csc_wr) begin
                csc_q[`TMCH_CSC_IE:`TMCH_CSC_ELS_A] <= csc_new[`TMCH_CSC_IE:`TMCH_CSC_ELS_A];
            end

            // flag: event wins over a clearing write
            if (ch_evt) begin
                csc_q[`TMCH_CSC_FLAG] <= 1'b1;
                armed_q               <= 1'b0;
            end else if (csc_wr && armed_q && !csc_new[`TMCH_CSC_FLAG]) begin
                csc_q[`TMCH_CSC_FLAG] <= 1'b0;
                armed_q               <= 1'b0;
            end else if (csc_rd && flag) begin
                armed_q <= 1'b1;
            end else if (csc_wr) begin
                armed_q <= 1'b0;
            end

            if (wr_fire && (wr_addr == `TMCH_ADDR_CTRL)) begin
                cas_q <= ctrl_new[`TMCH_CTRL_CAS];
                en_q  <= ctrl_new[`TMCH_CTRL_EN];
            end
            if (wr_fire && (wr_addr == `TMCH_ADDR_MOD)) begin
                mod_q <= mod_new[CW-1:0];
            end

            // capture beats a software write in the same cycle
            if (cap_evt) begin
                chv_q <= cnt;
            end else if (wr_fire && (wr_addr == `TMCH_ADDR_CHV)) begin
                chv_q <= chv_new[CW-1:0];
            end

            if (wr_fire && (wr_addr == `TMCH_ADDR_IMASK)) begin
                imask_q <= imask_new[`TMCH_IRQ_W-1:0];
            end

            // sticky status, write one to clear, set wins
            ists_q[`TMCH_IRQ_CH] <= ch_evt ||
                (ists_q[`TMCH_IRQ_CH] && !(wr_fire && (wr_addr == `TMCH_ADDR_ISTS) && ists_wr[`TMCH_IRQ_CH]));
            ists_q[`TMCH_IRQ_OVF] <= ovf ||
                (ists_q[`TMCH_IRQ_OVF] && !(wr_fire && (wr_addr == `TMCH_ADDR_ISTS) && ists_wr[`TMCH_IRQ_OVF]));
        end
    end

    assign O_CH_PIN       = pin_q;
    assign O_CH_PIN_OE_N  = !(pin_used && !mode_ic);
    assign O_PIN_RELEASED = !pin_used;
    assign O_CH_IRQ       = flag && csc_q[`TMCH_CSC_IE];
    assign O_IRQ          = |(ists_q & imask_q);
endmodule

// ### sim/tmch_pin_src.sv
// Purpose: source or load on the channel pin
// Assumes: bench commands the level through i_level
// Notes:   wire follows the block while it drives, else the source
`timescale 1ns/1ps
module tmch_pin_src (
    input  wire i_level,
    input  wire i_drv,
    input  wire i_oe_n,
    output wire o_pin
);
    // source moves only when told, so it sits still before capture
    assign o_pin = i_oe_n ? i_level : i_drv;
endmodule

// ### sim/tmch_properties.sv
// Purpose: port-level properties of the timer channel block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into tmch_top
`timescale 1ns/1ps
module tmch_properties (
    input logic        I_CLK, I_RSTN, I_AWVALID, O_AWREADY, I_WVALID, O_WREADY,
    input logic        O_BVALID, I_BREADY, I_ARVALID, O_ARREADY, O_RVALID, I_RREADY,
    input logic [1:0]  O_BRESP,
    input logic [31:0] O_RDATA,
    input logic        O_CH_PIN, O_CH_PIN_OE_N, O_PIN_RELEASED, O_CH_IRQ
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    property p_rel_oe; O_PIN_RELEASED |-> O_CH_PIN_OE_N; endproperty
    a_rel_oe: assert property (p_rel_oe) else $error("pin driven while released");
    property p_pin_idle; O_CH_PIN_OE_N && $past(O_CH_PIN_OE_N) |-> $stable(O_CH_PIN); endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin moved while undriven");
    property p_irq_fall; $fell(O_CH_IRQ) |-> $rose(O_BVALID); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("channel irq fell without write");
    property p_rst; $rose(I_RSTN) |-> !O_CH_IRQ && O_PIN_RELEASED && O_CH_PIN_OE_N; endproperty
    a_rst: assert property (p_rst) else $error("channel not idle after reset");
    property p_wr_lat; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> O_BVALID; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_lat; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_rd_gap; O_RVALID |-> !O_ARREADY; endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("read accepted while busy");
    c_irq: cover property ($rose(O_CH_IRQ));
    c_drive: cover property ($fell(O_CH_PIN_OE_N));
    c_err: cover property (O_BVALID && O_BRESP == 2'h2);
endmodule
bind tmch_top tmch_properties u_props (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY), .O_BRESP(O_BRESP), .O_RDATA(O_RDATA), .O_CH_PIN(O_CH_PIN),
    .O_CH_PIN_OE_N(O_CH_PIN_OE_N), .O_PIN_RELEASED(O_PIN_RELEASED), .O_CH_IRQ(O_CH_IRQ));

// ### sim/tb.sv
// Purpose: self-checking bench for the timer channel block
// Assumes: bus master and pin source driven from here
// Notes:   reads and write responses are checked from queues
`timescale 1ns/1ps
`include "tmch_map.vh"
module tb;
    logic        clk, rstn, awv, wv, bre, arv, rre, lvl;
    logic [7:0]  awa, ara;
    logic [31:0] wd;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          errors, total_checks, cyc;
    wire  [31:0] rdat;
    wire  [1:0]  rrsp, brsp;
    wire         awr, wrd, bv, arr, rv, pout, oen, rel, chirq, irq, pin;
    tmch_top dut (.I_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awa), .I_AWVALID(awv),
        .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wrd),
        .O_BRESP(brsp), .O_BVALID(bv), .I_BREADY(bre), .I_ARADDR(ara), .I_ARVALID(arv),
        .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rrsp), .O_RVALID(rv), .I_RREADY(rre),
        .I_CH_PIN(pin), .O_CH_PIN(pout), .O_CH_PIN_OE_N(oen), .O_PIN_RELEASED(rel),
        .O_CH_IRQ(chirq), .O_IRQ(irq));
    tmch_pin_src u_src (.i_level(lvl), .i_drv(pout), .i_oe_n(oen), .o_pin(pin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results;
        end
        if (rv === 1'b1 && rre)
            chk("read", {rrsp, rdat}, rq.pop_front());
        if (bv === 1'b1 && bre)
            chk("bresp", brsp, bq.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        bit ad, wdn;
        bq.push_back(r);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            ad |= awr;
            wdn |= wrd;
            awv <= !ad;
            wv <= !wdn;
        end while (!(ad && wdn));
        while (bv !== 1'b1) @(posedge clk);
        bre <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        rq.push_back({r, d});
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rre <= 1'b0;
    endtask
    // arming read with the flag up, then a zero written to it
    task automatic clr(input logic [7:0] c);
        rd(`TMCH_ADDR_CSC, {24'h0, c | 8'h80});
        wr(`TMCH_ADDR_CSC, {24'h0, c & 8'h7f});
    endtask
    task automatic wt;
        while (chirq !== 1'b1) @(posedge clk);
    endtask
    // counter restarted from zero, two match events observed
    task automatic pw(input logic [7:0] ctl, input logic [7:0] c, input logic p1, input logic p2);
        logic [15:0] v;
        logic        r;
        v = 16'($urandom_range(24, 8));
        r = c[3:2] == 2'b00;
        wr(`TMCH_ADDR_CHV, {16'h0, v});
        rd(`TMCH_ADDR_CHV, {16'h0, v});
        wr(`TMCH_ADDR_CSC, {24'h0, c});
        wr(`TMCH_ADDR_CNT, 32'h0);
        wr(`TMCH_ADDR_CTRL, {24'h0, ctl});
        wt();
        chk("pin first", {rel, oen, pout}, {r, r, p1});
        clr(c);
        wt();
        chk("pin second", {rel, oen, pout}, {r, r, p2});
        wr(`TMCH_ADDR_CTRL, 32'h0);
        clr(c);
    endtask
    initial begin
        logic [7:0] c;
        logic [2:0] rn;
        {rstn, awv, wv, bre, arv, rre, lvl, awa, ara, wd} = '0;
        void'($urandom(49452));
        rn = 3'($urandom);
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("reset pins", {rel, oen, chirq, irq}, 4'hc);
        for (int i = 0; i < 7; i++)
            rd(8'(i * 4), 32'h0);
        rd(8'h1c, 32'h0, 2'h2);
        wr(8'h1c, 32'hffff_ffff, 2'h2);
        wr(`TMCH_ADDR_CSC, 32'h80);
        rd(`TMCH_ADDR_CSC, 32'h0);
        for (int e = 1; e < 4; e++) begin
            c = 8'h40 | 8'(e << 2);
            wr(`TMCH_ADDR_CSC, {24'h0, c});
            lvl <= 1'b1;
            repeat (6) @(posedge clk);
            chk("rise irq", chirq, e[0]);
            if (e[0]) clr(c);
            lvl <= 1'b0;
            repeat (6) @(posedge clk);
            chk("fall irq", chirq, e[1]);
            if (e[1]) clr(c);
        end
        wr(`TMCH_ADDR_CSC, 32'h40);
        lvl <= 1'b1;
        repeat (6) @(posedge clk);
        chk("released", {rel, chirq}, 2'b10);
        wr(`TMCH_ADDR_CHV, 32'h0000_1234);
        wr(`TMCH_ADDR_CSC, 32'h4c);
        lvl <= 1'b0;
        repeat (6) @(posedge clk);
        rd(`TMCH_ADDR_CHV, 32'h0);
        rd(`TMCH_ADDR_CSC, 32'hcc);
        lvl <= 1'b1;
        repeat (6) @(posedge clk);
        wr(`TMCH_ADDR_CSC, 32'h4c);
        wr(`TMCH_ADDR_CSC, 32'h0c);
        chk("enable off", chirq, 1'b0);
        rd(`TMCH_ADDR_CSC, 32'h8c);
        rd(`TMCH_ADDR_ISTS, 32'h1);
        chk("irq masked", irq, 1'b0);
        wr(`TMCH_ADDR_IMASK, 32'h1);
        chk("irq unmasked", irq, 1'b1);
        wr(`TMCH_ADDR_ISTS, 32'h1);
        rd(`TMCH_ADDR_ISTS, 32'h0);
        chk("irq cleared", irq, 1'b0);
        wr(`TMCH_ADDR_CSC, 32'h0c);
        rd(`TMCH_ADDR_CSC, 32'h0c);
        wr(`TMCH_ADDR_MOD, 32'h20);
        rd(`TMCH_ADDR_MOD, 32'h20);
        pw(8'h01, 8'h5c, 1'b1, 1'b1);
        pw(8'h01, 8'h58, 1'b0, 1'b0);
        pw(8'h01, 8'h54, 1'b1, 1'b0);
        pw(8'h01, 8'h50, 1'b0, 1'b0);
        pw(8'h01, {3'b011, rn[0], 4'h8}, 1'b0, 1'b0);
        pw(8'h01, {3'b011, rn[0], rn[1], 3'b100}, 1'b1, 1'b1);
        pw(8'h21, {2'b01, rn[1:0], 4'h8}, 1'b0, 1'b1);
        pw(8'h21, {2'b01, rn[1:0], rn[2], 3'b100}, 1'b1, 1'b0);
        rd(`TMCH_ADDR_ISTS, 32'h3);
        results;
    end
endmodule
